// [asc_channel.sv]
`timescale 1ns/100ps
`include "asc_map.svh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module asc_channel
    import asc_pkg::*;
(
    // clock and reset (clk is the crystal clock)
    input  wire logic       clk,
    input  wire logic       rst_n,
    // baud clocks, pins from outside the domain
    input  wire logic       tx_baud_clk,
    input  wire logic       rx_baud_clk,
    // command port, one-cycle strobe
    input  wire logic       cmd_wr,
    input  wire logic [7:0] cmd_code,
    // mode configuration
    input  wire logic [1:0] bits_per_char,
    input  wire logic [1:0] parity_mode,
    input  wire logic       parity_odd,
    input  wire logic [1:0] stop_bits,
    input  wire logic       tx_x1_mode,
    input  wire logic       rx_x1_mode,
    input  wire logic       block_err_mode,
    input  wire logic       rx_int_sel_full,
    input  wire logic       cts_enable,
    input  wire logic       tx_rts_ctrl,
    input  wire logic       rx_rts_ctrl,
    // cpu data access
    input  wire logic       thr_wr,
    input  wire logic [7:0] thr_data,
    input  wire logic       rhr_rd,
    output logic      [7:0] rhr_data,
    output logic      [7:0] channel_status_reg,
    output logic            rx_int_req,
    // serial pins
    input  wire logic       serial_in,
    input  wire logic       clear_to_send_n,
    output logic            serial_out,
    output logic            request_to_send_n
);

    typedef struct packed {
        logic [1:0]    s_txc, s_rxc, s_rxd, s_cts;
        logic          tx_en, rx_en, brk;
        logic          thr_full;
        logic [7:0]    tx_holding_reg;
        asc_tx_state_t tst;
        logic [9:0]    tsh;
        logic [3:0]    tbits;
        logic [4:0]    tdiv;
        logic          tpar_pend;
        logic          rts_arm;
        asc_rx_state_t rst;
        logic [4:0]    rdiv;
        logic [3:0]    rbits;
        logic [8:0]    rsh;
        logic          rx_any_high;
        logic          hold_full;
        asc_entry_t    hold;
        logic [1:0]    brk_cnt;
        asc_entry_t [2:0] fifo;
        logic [1:0]    rp, wp, cnt;
        logic [2:0]    blk_err;
        logic          ovr;
        logic          rts_n;
        logic          rx_rts_neg;
        logic          sout;
        logic [7:0]    rdo;
        logic [7:0]    sro;
        logic          irq;
    } asc_state_t;

    asc_state_t st_ff, nxt_st;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] data_len(input logic [1:0] b);
        data_len = 4'd5 + {2'b00, b};
    endfunction

    function automatic logic [1:0] ptr_inc(input logic [1:0] p);
        ptr_inc = (p == 2'd2) ? 2'd0 : p + 2'd1;
    endfunction

    // parity over a masked byte; force mode sends the odd/even bit itself
    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] m, input logic odd);
        par_bit = (m == `ASC_PAR_FORCE) ? odd : ((^d) ^ odd);
    endfunction

    function automatic logic [7:0] len_mask(input logic [7:0] d, input logic [1:0] b);
        len_mask = d & (8'hFF >> (3'd3 - {1'b0, b}));
    endfunction

    logic tx_tick, rx_tick;
    logic [4:0] tx_bit_len, rx_bit_len;
    logic [3:0] rx_len;
    logic [7:0] rx_byte;
    logic rx_par_err, rx_frm, rx_brk;

    // baud rising edge detection compares both sync stages, new at bit 1, old at bit 0
    assign tx_tick = st_ff.s_txc[1] & ~st_ff.s_txc[0];
    assign rx_tick = st_ff.s_rxc[1] & ~st_ff.s_rxc[0];
    assign tx_bit_len = tx_x1_mode ? 5'd1 : `ASC_OVS;
    assign rx_bit_len = rx_x1_mode ? 5'd1 : `ASC_OVS;
    assign rx_len     = data_len(bits_per_char);
    // unused high bits read as zero
    assign rx_byte    = len_mask(st_ff.rsh[7:0] >> (4'd8 - rx_len), bits_per_char);
    assign rx_par_err = (parity_mode == `ASC_PAR_WITH || parity_mode == `ASC_PAR_FORCE) &&
                        (st_ff.rsh[8] != par_bit(rx_byte, parity_mode, parity_odd));
    assign rx_frm     = ~st_ff.s_rxd[1];
    assign rx_brk     = rx_frm && !st_ff.rx_any_high;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic pop;
        logic has_par;
        logic [4:0] stop_len;
        asc_entry_t ent;
        nxt_st = st_ff;
        pop = 1'b0;
        has_par = (parity_mode == `ASC_PAR_WITH || parity_mode == `ASC_PAR_FORCE);
        stop_len = {3'b000, stop_bits} + 5'd1;
        ent = '0;
        // two-flop synchronisers, oldest at bit 0
        nxt_st.s_txc = {tx_baud_clk, st_ff.s_txc[1]};
        nxt_st.s_rxc = {rx_baud_clk, st_ff.s_rxc[1]};
        nxt_st.s_rxd = {serial_in, st_ff.s_rxd[1]};
        nxt_st.s_cts = {clear_to_send_n, st_ff.s_cts[1]};

        // command decode
        if (cmd_wr) begin
            if (cmd_code[`ASC_EN_TX_BIT])  nxt_st.tx_en = 1'b1;
            if (cmd_code[`ASC_DIS_TX_BIT]) begin
                nxt_st.tx_en = 1'b0;
                nxt_st.rts_arm = tx_rts_ctrl;
            end
            if (cmd_code[`ASC_EN_RX_BIT])  nxt_st.rx_en = 1'b1;
            if (cmd_code[`ASC_DIS_RX_BIT]) nxt_st.rx_en = 1'b0;
        end

        // ---------------- transmitter ----------------
        // writes dropped while disabled
        if (thr_wr && st_ff.tx_en && !st_ff.thr_full) begin
            nxt_st.tx_holding_reg = thr_data;
            nxt_st.thr_full = 1'b1;
        end
        if (tx_tick) begin
            unique case (st_ff.tst)
                TX_IDLE: begin
                    // start only with clear to send when cts_enable is set
                    if (st_ff.thr_full && !(cts_enable && st_ff.s_cts[0])) begin
                        nxt_st.tsh = {2'b00, len_mask(st_ff.tx_holding_reg, bits_per_char)};
                        nxt_st.tpar_pend = has_par;
                        nxt_st.thr_full = 1'b0;
                        nxt_st.tst = TX_START;
                        nxt_st.tdiv = 5'd0;
                        nxt_st.sout = 1'b0;
                    end
                end
                default: begin
                    if (st_ff.tdiv == tx_bit_len - 5'd1) begin
                        nxt_st.tdiv = 5'd0;
                        if (st_ff.tst == TX_START) begin
                            nxt_st.tst = TX_DATA;
                            nxt_st.tbits = 4'd1;
                            nxt_st.sout = st_ff.tsh[0];
                        end else if (st_ff.tst == TX_DATA && st_ff.tbits < data_len(bits_per_char)) begin
                            nxt_st.tbits = st_ff.tbits + 4'd1;
                            nxt_st.sout = st_ff.tsh[st_ff.tbits];
                        end else if (st_ff.tst == TX_DATA && st_ff.tpar_pend) begin
                            nxt_st.tpar_pend = 1'b0;
                            nxt_st.sout = par_bit(st_ff.tsh[7:0], parity_mode, parity_odd);
                        end else if (st_ff.tst == TX_DATA) begin
                            nxt_st.tst = TX_STOP;
                            nxt_st.tbits = 4'd0;
                            nxt_st.sout = 1'b1;
                        end else if ({1'b0, st_ff.tbits} + 5'd1 < stop_len) begin
                            nxt_st.tbits = st_ff.tbits + 4'd1;
                        end else begin
                            nxt_st.tst = TX_IDLE;
                        end
                    end else begin
                        nxt_st.tdiv = st_ff.tdiv + 5'd1;
                    end
                end
            endcase
        end
        // rts drops a bit after drain when disabled
        if (st_ff.rts_arm && st_ff.tst == TX_IDLE && !st_ff.thr_full && tx_tick) begin
            if (st_ff.tdiv == tx_bit_len - 5'd1) begin
                nxt_st.rts_n = 1'b1;
                nxt_st.rts_arm = 1'b0;
            end else begin
                nxt_st.tdiv = st_ff.tdiv + 5'd1;
            end
        end
        if (cmd_wr && cmd_code[7:4] == `ASC_CMD_BRK_START) nxt_st.brk = 1'b1;
        if (cmd_wr && cmd_code[7:4] == `ASC_CMD_BRK_STOP)  nxt_st.brk = 1'b0;
        if (cmd_wr && cmd_code[7:4] == `ASC_CMD_TX_RESET) begin
            nxt_st.tst = TX_IDLE;
            nxt_st.tx_en = 1'b0;
            nxt_st.thr_full = 1'b0;
            nxt_st.brk = 1'b0;
            nxt_st.sout = 1'b1;
            nxt_st.rts_arm = 1'b0;
        end

        // ---------------- receiver ----------------
        if (rhr_rd && st_ff.cnt != 2'd0) pop = 1'b1;
        if (rx_tick && st_ff.rx_en) begin
            unique case (st_ff.rst)
                RX_HUNT: begin
                    if (!st_ff.s_rxd[0]) begin
                        nxt_st.rst = RX_START;
                        nxt_st.rdiv = 5'd0;
                    end
                end
                RX_START: begin
                    if (rx_x1_mode || st_ff.rdiv == `ASC_HALF_START) begin
                        if (st_ff.s_rxd[0]) begin
                            nxt_st.rst = RX_HUNT;
                        end else begin
                            nxt_st.rst = RX_DATA;
                            nxt_st.rdiv = 5'd0;
                            nxt_st.rbits = 4'd0;
                            nxt_st.rsh = '0;
                            nxt_st.rx_any_high = 1'b0;
                            if (st_ff.hold_full && st_ff.cnt == `ASC_FIFO_DEPTH) begin
                                nxt_st.hold_full = 1'b0;
                                nxt_st.ovr = 1'b1;
                            end
                            // rts off when start seen full
                            if (rx_rts_ctrl && st_ff.cnt == `ASC_FIFO_DEPTH) begin
                                nxt_st.rx_rts_neg = 1'b1;
                            end
                        end
                    end else begin
                        nxt_st.rdiv = st_ff.rdiv + 5'd1;
                    end
                end
                RX_DATA, RX_STOP: begin
                    if (st_ff.rdiv == rx_bit_len - 5'd1) begin
                        nxt_st.rdiv = 5'd0;
                        if (st_ff.rst == RX_DATA) begin
                            nxt_st.rsh = {st_ff.s_rxd[0], st_ff.rsh[8:1]};
                            nxt_st.rx_any_high = st_ff.rx_any_high | st_ff.s_rxd[0];
                            nxt_st.rbits = st_ff.rbits + 4'd1;
                            if (st_ff.rbits + 4'd1 == rx_len + {3'b000, has_par}) begin
                                nxt_st.rst = RX_STOP;
                                if (!has_par) nxt_st.rsh = {1'b0, st_ff.s_rxd[0], st_ff.rsh[8:2]};
                            end
                        end else begin
                            ent.brk = rx_brk;
                            ent.frm_err = rx_frm;
                            ent.par_err = rx_par_err & !rx_brk;
                            ent.data = rx_brk ? 8'h00 : rx_byte;
                            nxt_st.hold = ent;
                            nxt_st.hold_full = 1'b1;
                            if (rx_brk) begin
                                nxt_st.rst = RX_BREAK;
                                nxt_st.brk_cnt = 2'd0;
                            end else if (rx_frm && rx_byte != 8'h00) begin
                                // framing error: recheck half bit later
                                nxt_st.rst = RX_START;
                                nxt_st.rdiv = 5'd0;
                            end else begin
                                nxt_st.rst = RX_HUNT;
                            end
                        end
                    end else begin
                        nxt_st.rdiv = st_ff.rdiv + 5'd1;
                    end
                end
                default: ;
            endcase
        end
        // break end after two crystal edges high
        if (st_ff.rst == RX_BREAK) begin
            if (st_ff.s_rxd[0]) begin
                nxt_st.brk_cnt = st_ff.brk_cnt + 2'd1;
                if (st_ff.brk_cnt + 2'd1 == `ASC_BRK_END_EDGES) nxt_st.rst = RX_HUNT;
            end else begin
                nxt_st.brk_cnt = 2'd0;
            end
        end

        if (pop) begin
            nxt_st.rp = ptr_inc(st_ff.rp);
            if (block_err_mode) begin
                nxt_st.blk_err = st_ff.blk_err | {st_ff.fifo[ptr_inc(st_ff.rp)].brk,
                                  st_ff.fifo[ptr_inc(st_ff.rp)].frm_err,
                                  st_ff.fifo[ptr_inc(st_ff.rp)].par_err};
            end
        end
        if (st_ff.hold_full && (st_ff.cnt != `ASC_FIFO_DEPTH || pop)) begin
            nxt_st.fifo[st_ff.wp] = st_ff.hold;
            nxt_st.wp = ptr_inc(st_ff.wp);
            nxt_st.hold_full = 1'b0;
            if (nxt_st.hold_full == 1'b0 && st_ff.cnt == 2'd0 || (pop && st_ff.cnt == 2'd1))
                nxt_st.blk_err = nxt_st.blk_err | {st_ff.hold.brk, st_ff.hold.frm_err,
                                                   st_ff.hold.par_err};
        end
        nxt_st.cnt = st_ff.cnt + {1'b0, nxt_st.wp != st_ff.wp} - {1'b0, pop};
        // rts back low once space frees
        if (st_ff.rx_rts_neg && nxt_st.cnt != `ASC_FIFO_DEPTH) nxt_st.rx_rts_neg = 1'b0;

        if (cmd_wr && cmd_code[7:4] == `ASC_CMD_ERR_RESET) begin
            nxt_st.blk_err = '0;
            nxt_st.ovr = 1'b0;
        end
        if (cmd_wr && cmd_code[7:4] == `ASC_CMD_RX_RESET) begin
            nxt_st.rx_en = 1'b0;
            nxt_st.rst = RX_HUNT;
            nxt_st.rp = 2'd0;
            nxt_st.wp = 2'd0;
            nxt_st.cnt = 2'd0;
            nxt_st.hold_full = 1'b0;
            nxt_st.blk_err = '0;
            nxt_st.ovr = 1'b0;
            nxt_st.rx_rts_neg = 1'b0;
        end
        if (!nxt_st.rx_en && nxt_st.rst != RX_BREAK) nxt_st.rst = RX_HUNT;

        // ---------------- registered outputs ----------------
        nxt_st.rdo = nxt_st.fifo[nxt_st.rp].data;
        nxt_st.sro[`ASC_SR_TX_HOLDING_EMPTY_FLAG] = nxt_st.tx_en & !nxt_st.thr_full;
        nxt_st.sro[`ASC_SR_TX_IDLE_FLAG] = nxt_st.tx_en & !nxt_st.thr_full & (nxt_st.tst == TX_IDLE);
        nxt_st.sro[`ASC_SR_RX_CHAR_AVAILABLE] = nxt_st.cnt != 2'd0;
        nxt_st.sro[`ASC_SR_RX_FIFO_FULL_FLAG] = nxt_st.cnt == `ASC_FIFO_DEPTH;
        nxt_st.sro[`ASC_SR_OVR]   = nxt_st.ovr;
        // char mode oldest entry, block mode accumulated
        if (block_err_mode) begin
            {nxt_st.sro[`ASC_SR_BRK], nxt_st.sro[`ASC_SR_FRM], nxt_st.sro[`ASC_SR_PAR]} =
                nxt_st.blk_err;
        end else begin
            ent = nxt_st.fifo[nxt_st.rp];
            nxt_st.sro[`ASC_SR_BRK] = ent.brk & (nxt_st.cnt != 2'd0);
            nxt_st.sro[`ASC_SR_FRM] = ent.frm_err & (nxt_st.cnt != 2'd0);
            nxt_st.sro[`ASC_SR_PAR] = ent.par_err & (nxt_st.cnt != 2'd0);
        end
        nxt_st.irq = rx_int_sel_full ? nxt_st.sro[`ASC_SR_RX_FIFO_FULL_FLAG] : nxt_st.sro[`ASC_SR_RX_CHAR_AVAILABLE];
        if (!nxt_st.tx_en && !nxt_st.rts_arm && nxt_st.rts_n && !tx_rts_ctrl)
            nxt_st.rts_n = 1'b0;
        if (cmd_wr && cmd_code[`ASC_EN_TX_BIT]) nxt_st.rts_n = 1'b0;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{s_txc: 2'b00, s_rxc: 2'b00, s_rxd: 2'b11, s_cts: 2'b11,
                       tst: TX_IDLE, rst: RX_HUNT, sout: 1'b1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // break forces line low; tx state runs on after disable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out <= 1'b1;
        end else begin
            serial_out <= nxt_st.sout & ~nxt_st.brk;
        end
    end

    assign rhr_data           = st_ff.rdo;
    assign channel_status_reg = st_ff.sro;
    assign rx_int_req         = st_ff.irq;
    assign request_to_send_n  = st_ff.rts_n | (rx_rts_ctrl & st_ff.rx_rts_neg);

endmodule

// [asc_channel_tb.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module asc_channel_tb;
    logic       clk = 0, rst_n = 0, bc = 0, cmd_wr = 0, thr_wr = 0, rhr_rd = 0, fe, wv = 0;
    logic       blk = 0, isel = 0, cts_en = 0, rrts = 0, cts_n = 0, trts = 0, podd = 0;
    logic [7:0] cmd_code = 0, thr_data = 0, rhr_data, sr, d, w;
    wire        so, si, rts_n, irq;
    int         num_errors = 0, num_checks = 0;
    logic [7:0] exp_q [$], fq [$];
    always #5 clk = ~clk;
    always #20 bc = ~bc; // 16x baud clock
    asc_channel u_dut (.clk(clk), .rst_n(rst_n), .tx_baud_clk(bc), .rx_baud_clk(bc),
        .cmd_wr(cmd_wr), .cmd_code(cmd_code), .bits_per_char(2'd3), .parity_mode(2'b10),
        .parity_odd(podd), .stop_bits(2'd0), .tx_x1_mode(1'b0), .rx_x1_mode(1'b0),
        .block_err_mode(blk), .rx_int_sel_full(isel), .cts_enable(cts_en), .tx_rts_ctrl(trts),
        .rx_rts_ctrl(rrts), .thr_wr(thr_wr), .thr_data(thr_data), .rhr_rd(rhr_rd),
        .rhr_data(rhr_data), .channel_status_reg(sr), .rx_int_req(irq), .serial_in(si),
        .clear_to_send_n(cts_n), .serial_out(so), .request_to_send_n(rts_n));
    asc_remote u_rem (.serial_out(so), .serial_in(si));
    task wt(input int n); repeat (n) @(negedge clk); endtask
    task cmd(input logic [7:0] c); wt(1); cmd_code = c; cmd_wr = 1; wt(1); cmd_wr = 0; wt(3); endtask
    task wr(input logic [7:0] v); wt(1); thr_data = v; thr_wr = 1; wt(1); thr_wr = 0; wt(2); endtask
    task rd(input logic [7:0] e); wt(2); `CHK("rhr_data", e, rhr_data)
        rhr_rd = 1; wt(1); rhr_rd = 0; wt(4); endtask
    task idle; for (int i = 0; i < 3000 && sr[3] !== 1'b1; i++) wt(1); wt(100); endtask
    // compare what the remote heard with the queued characters
    task chk_tx(input int n); `CHK("tx count", n, u_rem.rq.size())
        repeat (n) `CHK("tx char", exp_q.pop_front(), u_rem.rq.pop_front())
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin #900_000; num_errors++; report_and_stop; end
    initial begin
        void'($urandom(32'h30bf));
        wt(20); rst_n = 1; wt(2);
        cmd(8'h05);
        `CHK("tx ready", 1'b1, sr[2])
        repeat (2) begin d = 8'($urandom); exp_q.push_back(d); wr(d); wt(10); end
        `CHK("tx ready", 1'b0, sr[2])
        `CHK("tx idle", 1'b0, sr[3])
        idle; chk_tx(2); `CHK("line", 1'b1, so)
        `CHK("tx idle", 1'b1, sr[3])
        // disable mid character, then a refused write
        d = 8'($urandom); exp_q.push_back(d); wr(d); wt(100); cmd(8'h08); wr(8'($urandom));
        wt(1500); chk_tx(1); $display("test tx done");
        cmd(8'h04); cmd(8'h60); wt(300); `CHK("break line", 1'b0, so)
        cmd(8'h70); wt(300); u_rem.rq.delete();
        cts_en = 1; cts_n = 1; d = 8'($urandom); exp_q.push_back(d); wr(d); wt(1000);
        chk_tx(0); cts_n = 0; idle; chk_tx(1); cts_en = 0;
        wr(8'($urandom)); wt(200); cmd(8'h30); `CHK("reset line", 1'b1, so)
        wt(900); u_rem.rq.delete(); wr(8'($urandom)); wt(900); chk_tx(0);
        $display("test tx control done");
        // fill the fifo, one waiting, one overrunning
        rrts = 1;
        for (int i = 0; i < 5; i++) begin
            d = 8'($urandom); u_rem.send(d, 0); wt(20);
            if (fq.size() < 3) fq.push_back(d); else begin w = d; wv = 1; end
            `CHK("full", fq.size() == 3, sr[1])
        end
        `CHK("overrun", 1'b1, sr[4])
        `CHK("rts", 1'b1, rts_n)
        isel = 1; wt(3); `CHK("irq", 1'b1, irq)
        while (fq.size()) begin rd(fq.pop_front()); if (wv) fq.push_back(w); wv = 0; end
        `CHK("rts", 1'b0, rts_n)
        `CHK("ready", 1'b0, sr[0])
        rrts = 0; isel = 0; cmd(8'h40); $display("test rx fifo done");
        d = 8'($urandom) | 8'h01; u_rem.send(d, 1); wt(20); `CHK("frame", 1'b1, sr[6])
        rd(d); u_rem.low(640.0 * 12); wt(20); `CHK("rx break", 1'b1, sr[7])
        rd(8'h00); d = 8'($urandom); u_rem.send(d, 0); wt(20); rd(d);
        u_rem.low(200.0); wt(1200); `CHK("false start", 1'b0, sr[0])
        // block mode keeps framing status past the bad character
        blk = 1; d = 8'h81; u_rem.send(d, 1); u_rem.send(8'h42, 0); wt(20); rd(d);
        `CHK("block frame", 1'b1, sr[6])
        cmd(8'h40); `CHK("err reset", 1'b0, sr[6])
        rd(8'h42); $display("test rx status done");
        report_and_stop;
    end
endmodule

// [asc_map.svh]
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// command codes on the 8-bit command port (high nibble of the command byte)
`define ASC_CMD_NOP        4'h0
`define ASC_CMD_RX_RESET   4'h2
`define ASC_CMD_TX_RESET   4'h3
`define ASC_CMD_ERR_RESET  4'h4
`define ASC_CMD_BRK_START  4'h6
`define ASC_CMD_BRK_STOP   4'h7
// enable/disable fields (low nibble)
`define ASC_EN_RX_BIT      0
`define ASC_DIS_RX_BIT     1
`define ASC_EN_TX_BIT      2
`define ASC_DIS_TX_BIT     3

// bit timing, fifo depth and break end
`define ASC_OVS            5'd16
`define ASC_HALF_START     5'd7
`define ASC_FIFO_DEPTH     2'd3
`define ASC_BRK_END_EDGES  2'd2

// status bit positions of channel_status_reg
`define ASC_SR_RX_CHAR_AVAILABLE       0
`define ASC_SR_RX_FIFO_FULL_FLAG       1
`define ASC_SR_TX_HOLDING_EMPTY_FLAG       2
`define ASC_SR_TX_IDLE_FLAG       3
`define ASC_SR_OVR         4
`define ASC_SR_PAR         5
`define ASC_SR_FRM         6
`define ASC_SR_BRK         7

// parity modes
`define ASC_PAR_WITH       2'b00
`define ASC_PAR_FORCE      2'b01
`define ASC_PAR_NONE       2'b10

`endif

// [asc_pkg.sv]
package asc_pkg;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA  = 4'b0100,
        TX_STOP  = 4'b1000
    } asc_tx_state_t;

    typedef enum logic [4:0] {
        RX_HUNT  = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA  = 5'b00100,
        RX_STOP  = 5'b01000,
        RX_BREAK = 5'b10000
    } asc_rx_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       par_err;
        logic       frm_err;
        logic       brk;
    } asc_entry_t;

endpackage

// [asc_props.sv]
`timescale 1ns/100ps
`include "asc_map.svh"
module asc_props (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // watched ports
    input wire logic       cmd_wr,
    input wire logic [7:0] cmd_code,
    input wire logic       thr_wr,
    input wire logic       rhr_rd,
    input wire logic       rx_int_sel_full,
    input wire logic       rx_rts_ctrl,
    input wire logic [7:0] channel_status_reg,
    input wire logic       rx_int_req,
    input wire logic       serial_out,
    input wire logic       request_to_send_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic       brk_ff;
    logic       ten_ff;
    logic       nxt_brk;
    logic [6:0] age_ff;
    wire  [3:0] op = cmd_code[7:4];
    wire  [7:0] sr = channel_status_reg;
    // break state from commands; age covers the line settling after a change
    assign nxt_brk = (cmd_wr && op == `ASC_CMD_BRK_START) ? 1'b1 :
                     (cmd_wr && op == `ASC_CMD_BRK_STOP) ? 1'b0 : brk_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brk_ff <= 1'b0;
            ten_ff <= 1'b0;
            age_ff <= 7'h00;
        end else begin
            brk_ff <= nxt_brk;
            age_ff <= (nxt_brk != brk_ff) ? 7'h00 : (age_ff == 7'd127 ? age_ff : age_ff + 7'd1);
            ten_ff <= (cmd_wr && cmd_code[2]) ? 1'b1 :
                      (cmd_wr && (cmd_code[3] || op == `ASC_CMD_TX_RESET)) ? 1'b0 : ten_ff;
        end
    end
    sequence s_tx_rst;
        cmd_wr && op == `ASC_CMD_TX_RESET && !brk_ff;
    endsequence
    sequence s_mark;
        serial_out [*8];
    endsequence
    a_idle_line_high: assert property (
        sr[3] && !brk_ff && age_ff == 7'd127 |-> serial_out) else $error("idle line low");
    a_write_clears_idle: assert property (
        thr_wr && ten_ff && sr[2] && sr[3] |-> ##[1:3] !sr[3]) else $error("idle kept");
    a_full_has_char: assert property (
        sr[1] |-> sr[0]) else $error("full without char");
    a_int_source_sel: assert property (
        (rx_int_sel_full ? sr[1] : sr[0]) |-> ##[0:1] rx_int_req) else $error("no rx irq");
    a_break_line_low: assert property (
        brk_ff && age_ff == 7'd127 |-> !serial_out) else $error("break not low");
    a_ready_by_read: assert property (
        $fell(sr[0]) |-> $past(rhr_rd) || $past(cmd_wr && op == `ASC_CMD_RX_RESET))
        else $error("char lost without read");
    a_tx_reset_mark: assert property (
        s_tx_rst |-> ##[1:4] s_mark) else $error("tx reset did not stop");
    a_rts_on_free: assert property (
        rx_rts_ctrl && $fell(sr[1]) |-> ##[0:2] !request_to_send_n) else $error("rts stuck");
endmodule
bind asc_channel asc_props u_props (.clk(clk), .rst_n(rst_n), .cmd_wr(cmd_wr),
    .cmd_code(cmd_code), .thr_wr(thr_wr), .rhr_rd(rhr_rd), .rx_int_sel_full(rx_int_sel_full),
    .rx_rts_ctrl(rx_rts_ctrl), .channel_status_reg(channel_status_reg),
    .rx_int_req(rx_int_req), .serial_out(serial_out), .request_to_send_n(request_to_send_n));

// [asc_remote.sv]
`timescale 1ns/100ps
module asc_remote #(parameter real BIT_NS = 640.0) (
    // serial lines seen from the remote end
    input  wire logic serial_out,
    output logic      serial_in
);
    logic [7:0] rq [$];
    initial serial_in = 1'b1;
    // start, lsb first, one stop; fe holds the stop bit low for three quarters of a bit
    task automatic send(input logic [7:0] d, input bit fe);
        serial_in = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++) begin
            serial_in = d[i];
            #(BIT_NS);
        end
        serial_in = !fe;
        #(BIT_NS * 0.75);
        serial_in = 1'b1;
        #(BIT_NS * 1.25);
    endtask
    // low pulse of given length, for breaks and false starts
    task automatic low(input real ns);
        serial_in = 1'b0;
        #(ns);
        serial_in = 1'b1;
    endtask
    // centre sampling listener, eight data bits
    initial begin
        logic [7:0] c;
        forever begin
            @(negedge serial_out);
            #(BIT_NS / 2);
            if (!serial_out) begin
                for (int i = 0; i < 8; i++) begin
                    #(BIT_NS);
                    c[i] = serial_out;
                end
                rq.push_back(c);
                #(BIT_NS);
            end
        end
    end
endmodule
